// file: design/ipa_pkg.sv
package ipa_pkg;

  // Widths of the data space
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PTR = 3;

  // Locally held registers inside the top page
  localparam logic [11:0] ADDR_FLAGS = 12'hfc0;
  localparam logic [11:0] ADDR_BANK = 12'hfc1;
  localparam logic [11:0] ADDR_PTR_BASE = 12'hfc2;
  localparam logic [11:0] ADDR_PTR_STRIDE = 12'h002;

  // Virtual operand windows, five addresses per pointer
  localparam logic [11:0] ADDR_VIRT_BASE = 12'hfd0;
  localparam logic [11:0] VIRT_STRIDE = 12'h008;
  localparam logic [11:0] VIRT_MODES = 12'h005;

  // Access bank split for unbanked operands
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;

  // Reset values and fixed fields
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [2:0] FLAGS_PAD = 3'h0;
  localparam logic [3:0] PTR_HIGH_PAD = 4'h0;
  localparam logic [3:0] BANK_PAD = 4'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Bit positions used by the flag logic
  localparam int NIBBLE_CARRY_BIT = 4;
  localparam int DC_ROT_LEFT_BIT = 3;
  localparam int DC_ROT_RIGHT_BIT = 4;

  // Pointer access modes, ordered as the window offsets
  typedef enum logic [2:0] {
    PM_PLAIN, PM_POSTDEC, PM_POSTINC, PM_PREINC, PM_INDEXED
  } ipa_mode_t;

  // Operations reported by the execution stage
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_ROT_LEFT, ALU_ROT_RIGHT
  } ipa_alu_op_t;

  // Condition flags, packed in register bit order 4..0
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } ipa_flags_t;

  // One operand access from the execution stage
  typedef struct packed {
    logic write;
    logic use_bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ipa_acc_req_t;

  // One flag-updating operation
  typedef struct packed {
    ipa_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } ipa_alu_req_t;

  // Result of decoding a virtual operand address
  typedef struct packed {
    logic hit;
    logic [1:0] idx;
    ipa_mode_t mode;
  } ipa_virt_dec_t;

  // Result of decoding a pointer register address
  typedef struct packed {
    logic hit;
    logic [1:0] idx;
    logic high;
  } ipa_ptr_dec_t;

  // Virtual operand decode, used on operand and on target
  function automatic ipa_virt_dec_t ipa_virt_decode(input logic [11:0] a);
    ipa_virt_dec_t d;
    logic [11:0] off;
    d = '0;
    off = '0;
    for (int i = 0; i < NUM_PTR; i++) begin
      off = a - (ADDR_VIRT_BASE + 12'(i) * VIRT_STRIDE);
      if (off < VIRT_MODES) begin
        d.hit = 1'b1;
        d.idx = 2'(i);
        d.mode = ipa_mode_t'(off[2:0]);
      end
    end
    return d;
  endfunction

  // Pointer register decode, used on the target only
  function automatic ipa_ptr_dec_t ipa_ptr_decode(input logic [11:0] a);
    ipa_ptr_dec_t d;
    logic [11:0] base;
    d = '0;
    base = '0;
    for (int i = 0; i < NUM_PTR; i++) begin
      base = ADDR_PTR_BASE + 12'(i) * ADDR_PTR_STRIDE;
      if (a == base || a == base + 12'h001) begin
        d.hit = 1'b1;
        d.idx = 2'(i);
        d.high = (a != base);
      end
    end
    return d;
  endfunction

endpackage

// file: design/ipa_data_mem.sv
`timescale 1ns/1ps
module ipa_data_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, low
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] addr, // Byte address
  input wire logic [DW-1:0] wdata, // Write data
  output logic [DW-1:0] rdata // Registered read data
);

  // Storage has no reset, like any static RAM
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_next;

  // Read data always follows the address one cycle late
  always_comb begin
    rdata_next = mem[addr];
  end

  // Array write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read register, reset so the output is defined
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule // ipa_data_mem

// file: design/ipa_indirect_flags.sv
// How it works
// - Three 12-bit pointers, high and low bytes.
// - Virtual operand address accesses pointed location.
// - Reading virtual through pointer gives 00h, sets zero if no operation runs.
// - Writing virtual through pointer stores nothing; its pointer step still runs, and the same-cycle flag update is dropped.
// - Five addresses per pointer select access mode.
// - Pointer steps never touch condition flags.
// - Steps act on all 12 bits.
// - Indexed mode adds signed accumulator, nothing changes.
// - Write to pointer beats its own step.
// - Flag-updating operation overrides direct flag write.
// - Flags byte: zeros, N, OV, Z, DC, C.
// - Negative follows result bit seven.
// - Overflow on wrong sign change.
// - Zero set when result is zero.
// - Digit carry from low nibble on add/sub.
// - Carry out of bit seven on add/sub.
// - Subtract adds complement; carries mean no borrow.
// - Rotates load DC and C from source.
// - Bank select gives upper four address bits.
`timescale 1ns/1ps
module ipa_indirect_flags
  import ipa_pkg::*;
(
  input wire logic clk, // Core clock, 50 MHz
  input wire logic resetn, // Async reset, low
  input wire logic acc_valid, // Operand access this cycle
  input wire ipa_acc_req_t acc_req, // Operand address, direction, data
  input wire logic [7:0] working_accumulator, // Index for indexed mode
  input wire logic alu_valid, // Flag-updating operation this cycle
  input wire ipa_alu_req_t alu_req, // Operation and operands
  output logic acc_rvalid, // Read data valid
  output logic [7:0] acc_rdata, // Read data
  output logic [7:0] alu_result, // Operation result
  output logic [7:0] alu_condition_flags, // Flags byte
  output logic [11:0] pointer_zero, // Pointer 0
  output logic [11:0] pointer_one, // Pointer 1
  output logic [11:0] pointer_two, // Pointer 2
  output logic [3:0] bank_select_value // Bank select
);

  // Request decode, all combinational in cycle 0
  logic [11:0] req_addr; // Operand as a 12-bit address
  ipa_virt_dec_t vd; // Operand decode
  logic vh; // Access goes through a pointer
  logic [11:0] vptr; // Selected pointer value
  logic [11:0] sext_w; // Sign-extended accumulator
  logic [11:0] tgt; // Final access address
  ipa_virt_dec_t td; // Target decode
  logic tgt_virt; // Pointer lands on a virtual address
  ipa_ptr_dec_t pd; // Target is a pointer byte
  logic rd; // Qualified read
  logic wr; // Qualified write
  logic is_local; // Target held in this block
  logic mem_we; // Memory write strobe
  logic [7:0] mem_rdata; // Memory read data
  logic [7:0] local_rdata; // Local register read data
  logic [11:0] ptr_cur [NUM_PTR]; // Pointer values

  // Bank-relative or access-bank address formation
  always_comb begin
    if (acc_req.use_bank) begin
      req_addr = {bank_select_value, acc_req.addr};
    end else if (acc_req.addr < ACCESS_SPLIT) begin
      req_addr = {ACCESS_LOW_PAGE, acc_req.addr};
    end else begin
      req_addr = {ACCESS_HIGH_PAGE, acc_req.addr};
    end
  end

  // Resolve the virtual operand to its target
  always_comb begin
    vd = ipa_virt_decode(req_addr);
    vh = acc_valid && vd.hit;
    vptr = ptr_cur[vd.idx];
    sext_w = {{4{working_accumulator[7]}}, working_accumulator};
    tgt = req_addr;
    if (vh) begin
      case (vd.mode)
        PM_PREINC: tgt = vptr + 12'h001;
        PM_INDEXED: tgt = vptr + sext_w;
        default: tgt = vptr;
      endcase
    end
    td = ipa_virt_decode(tgt);
    tgt_virt = vh && td.hit;
    pd = ipa_ptr_decode(tgt);
    rd = acc_valid && !acc_req.write;
    wr = acc_valid && acc_req.write && !tgt_virt;
    is_local = pd.hit || tgt == ADDR_FLAGS || tgt == ADDR_BANK;
    mem_we = wr && !is_local;
  end

  // Local register readback, unimplemented bits as zero
  always_comb begin
    local_rdata = ZERO_BYTE;
    if (pd.hit && pd.high) begin
      local_rdata = {PTR_HIGH_PAD, ptr_cur[pd.idx][11:8]};
    end else if (pd.hit) begin
      local_rdata = ptr_cur[pd.idx][7:0];
    end else if (tgt == ADDR_FLAGS) begin
      local_rdata = alu_condition_flags;
    end else if (tgt == ADDR_BANK) begin
      local_rdata = {BANK_PAD, bank_select_value};
    end
  end

  // Pointer pair per index; a write to its own byte wins
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    logic [11:0] p_reg; // Current pointer
    logic [11:0] p_next; // Next pointer
    always_comb begin
      p_next = p_reg;
      if (vh && vd.idx == 2'(i)) begin
        case (vd.mode)
          PM_POSTDEC: p_next = p_reg - 12'h001;
          PM_POSTINC: p_next = p_reg + 12'h001;
          PM_PREINC: p_next = p_reg + 12'h001;
          default: p_next = p_reg;
        endcase
      end
      if (wr && pd.hit && pd.idx == 2'(i)) begin
        if (pd.high) begin
          p_next = {acc_req.wdata[3:0], p_reg[7:0]};
        end else begin
          p_next = {p_reg[11:8], acc_req.wdata};
        end
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        p_reg <= PTR_RESET;
      end else begin
        p_reg <= p_next;
      end
    end
    assign ptr_cur[i] = p_reg;
  end

  assign pointer_zero = g_ptr[0].p_reg;
  assign pointer_one = g_ptr[1].p_reg;
  assign pointer_two = g_ptr[2].p_reg;

  // Flag computation for the reported operation
  logic [7:0] b_eff; // Second operand, complemented on subtract
  logic [8:0] sum9; // Full sum with carry out
  logic [4:0] nib; // Low nibble sum with digit carry
  logic [7:0] res; // Operation result
  ipa_flags_t alu_flags; // Flags the operation produces
  ipa_flags_t flags_reg; // Stored flags, deliberately unreset
  ipa_flags_t flags_next;
  logic [7:0] alu_result_next;

  always_comb begin
    b_eff = (alu_req.op == ALU_SUB) ? ~alu_req.b : alu_req.b;
    sum9 = {1'b0, alu_req.a} + {1'b0, b_eff} + 9'(alu_req.op == ALU_SUB);
    nib = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + 5'(alu_req.op == ALU_SUB);
    alu_flags = flags_reg;
    case (alu_req.op)
      ALU_ADD, ALU_SUB: begin
        res = sum9[7:0];
        alu_flags.ov = (alu_req.a[7] == b_eff[7]) && (res[7] != alu_req.a[7]);
        alu_flags.dc = nib[NIBBLE_CARRY_BIT];
        alu_flags.c = sum9[8];
      end
      ALU_ROT_LEFT: begin
        res = {alu_req.a[6:0], alu_req.a[7]};
        alu_flags.dc = alu_req.a[DC_ROT_LEFT_BIT];
        alu_flags.c = alu_req.a[7];
      end
      ALU_ROT_RIGHT: begin
        res = {alu_req.a[0], alu_req.a[7:1]};
        alu_flags.dc = alu_req.a[DC_ROT_RIGHT_BIT];
        alu_flags.c = alu_req.a[0];
      end
      default: begin
        res = alu_req.b; // Logic result comes in ready-made
      end
    endcase
    alu_flags.n = res[7];
    alu_flags.z = (res == ZERO_BYTE);
    alu_result_next = alu_valid ? res : alu_result;
  end

  // Flag register next value; priority: operation, virtual read, write
  always_comb begin
    flags_next = flags_reg; // Pointer steps never reach here
    if (alu_valid && !(acc_valid && acc_req.write && tgt_virt)) begin
      flags_next = alu_flags;
    end else if (rd && tgt_virt) begin
      flags_next.z = 1'b1;
    end else if (wr && tgt == ADDR_FLAGS) begin
      flags_next = ipa_flags_t'(acc_req.wdata[4:0]);
    end
  end

  // No reset: contents unknown until first update
  always_ff @(posedge clk) begin
    flags_reg <= flags_next;
  end
  assign alu_condition_flags = {FLAGS_PAD, flags_reg};

  // Bank select and result register
  logic [3:0] bank_next;
  always_comb begin
    bank_next = bank_select_value;
    if (wr && tgt == ADDR_BANK) begin
      bank_next = acc_req.wdata[3:0];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank_select_value <= BANK_RESET;
      alu_result <= ZERO_BYTE;
    end else begin
      bank_select_value <= bank_next;
      alu_result <= alu_result_next;
    end
  end

  // Data memory; its read data is one cycle behind the address
  ipa_data_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .clk(clk),
    .resetn(resetn),
    .we(mem_we),
    .addr(tgt),
    .wdata(acc_req.wdata),
    .rdata(mem_rdata)
  );

  // Read pipeline: stage 1 waits for memory, stage 2 is the output
  logic s1_valid, s1_zero, s1_local;
  logic [7:0] s1_ldata;
  logic s1_valid_next, s1_zero_next, s1_local_next;
  logic [7:0] s1_ldata_next;
  logic rvalid_next;
  logic [7:0] rdata_next;

  always_comb begin
    s1_valid_next = rd;
    s1_zero_next = tgt_virt;
    s1_local_next = is_local;
    s1_ldata_next = local_rdata;
    rvalid_next = s1_valid;
    rdata_next = acc_rdata;
    if (s1_valid) begin
      rdata_next = s1_zero ? ZERO_BYTE : (s1_local ? s1_ldata : mem_rdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_valid <= 1'b0;
      s1_zero <= 1'b0;
      s1_local <= 1'b0;
      s1_ldata <= ZERO_BYTE;
      acc_rvalid <= 1'b0;
      acc_rdata <= ZERO_BYTE;
    end else begin
      s1_valid <= s1_valid_next;
      s1_zero <= s1_zero_next;
      s1_local <= s1_local_next;
      s1_ldata <= s1_ldata_next;
      acc_rvalid <= rvalid_next;
      acc_rdata <= rdata_next;
    end
  end

  // Checks next to the logic they guard
  logic step0;
  assign step0 = vh && vd.idx == 2'd0 && vd.mode == PM_POSTINC && !(wr && pd.hit);

  property p_rd_latency;
    @(posedge clk) disable iff (!resetn) rd |-> ##2 acc_rvalid;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer late");

  property p_virt_zero;
    @(posedge clk) disable iff (!resetn) (rd && tgt_virt) |-> ##2 (acc_rdata == ZERO_BYTE);
  endproperty
  a_virt_zero: assert property (p_virt_zero) else $error("virtual read not zero");

  property p_virt_z;
    @(posedge clk) disable iff (!resetn) (rd && tgt_virt && !alu_valid) |=> flags_reg.z;
  endproperty
  a_virt_z: assert property (p_virt_z) else $error("zero flag not set");

  property p_virt_wr;
    @(posedge clk) disable iff (!resetn)
      (acc_valid && acc_req.write && tgt_virt) |=> ($stable(flags_reg) && !$past(mem_we));
  endproperty
  a_virt_wr: assert property (p_virt_wr) else $error("virtual write acted");

  property p_postinc;
    @(posedge clk) disable iff (!resetn)
      (step0 && !alu_valid) |=> (pointer_zero == $past(pointer_zero) + 12'h001) && $stable(flags_reg);
  endproperty
  a_postinc: assert property (p_postinc) else $error("post step wrong");

  property p_indexed;
    @(posedge clk) disable iff (!resetn)
      (vh && vd.mode == PM_INDEXED && !(wr && pd.hit))
      |-> (tgt == vptr + sext_w) ##1 ($stable(pointer_zero) && $stable(pointer_one) && $stable(pointer_two));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed access wrong");

  property p_dominate;
    @(posedge clk) disable iff (!resetn)
      (wr && vh && pd.hit && !pd.high && pd.idx == vd.idx && vd.idx == 2'd0) |=>
      (pointer_zero[7:0] == $past(acc_req.wdata));
  endproperty
  a_dominate: assert property (p_dominate) else $error("step beat write");

  property p_flag_supp;
    @(posedge clk) disable iff (!resetn)
      (alu_valid && wr && tgt == ADDR_FLAGS) |=> (flags_reg == $past(alu_flags));
  endproperty
  a_flag_supp: assert property (p_flag_supp) else $error("direct flag write won");

  property p_pad;
    @(posedge clk) disable iff (!resetn) alu_condition_flags[7:5] == FLAGS_PAD;
  endproperty
  a_pad: assert property (p_pad) else $error("upper flag bits set");

  property p_sub_carry;
    @(posedge clk) disable iff (!resetn) (alu_valid && alu_req.op == ALU_SUB && !acc_valid)
      |=> (flags_reg.c == ($past(alu_req.a) >= $past(alu_req.b))) && (flags_reg.n == alu_result[7]);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("borrow flag wrong");

  property p_bank;
    @(posedge clk) disable iff (!resetn) (acc_valid && acc_req.use_bank && !vh)
      |-> (tgt[11:8] == bank_select_value);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not used");

  c_postinc: cover property (@(posedge clk) disable iff (!resetn) step0);
  c_virt_rd: cover property (@(posedge clk) disable iff (!resetn) rd && tgt_virt);
  c_dominate: cover property (@(posedge clk) disable iff (!resetn) wr && vh && pd.hit);
  c_wrap: cover property (@(posedge clk) disable iff (!resetn) step0 && pointer_zero == 12'hfff);

endmodule // ipa_indirect_flags

// file: testbench/ipa_exec_model.sv
`timescale 1ns/1ps
// Execution-stage stand-in: issues operand accesses and flag updates
module ipa_exec_model
  import ipa_pkg::*;
(
  input wire logic clk, // Core clock
  output logic acc_valid, // Operand access strobe
  output ipa_acc_req_t acc_req, // Access request
  output logic [7:0] working_accumulator, // Index for indexed mode
  output logic alu_valid, // Flag update strobe
  output ipa_alu_req_t alu_req, // Operation and operands
  input wire logic acc_rvalid, // Read answer strobe
  input wire logic [7:0] acc_rdata // Read answer data
);
  // Idle from time zero, qualifiers hold a junk pattern
  initial begin
    acc_valid = 1'b0;
    alu_valid = 1'b0;
    acc_req = ipa_acc_req_t'(18'h2a5a5);
    working_accumulator = 8'h5a;
    alu_req = ipa_alu_req_t'(19'h5a5a5);
  end

  // Released qualifiers flip so stale values never look valid
  task automatic scramble();
    acc_valid = 1'b0;
    alu_valid = 1'b0;
    acc_req = ipa_acc_req_t'(~acc_req);
    working_accumulator = ~working_accumulator;
    alu_req = ipa_alu_req_t'(~alu_req);
  endtask

  // One request cycle, then one idle cycle so strobes never retoggle in a step
  task automatic cyc(input logic av, input ipa_acc_req_t ar, input logic [7:0] wa,
                     input logic lv, input ipa_alu_req_t lr);
    acc_valid = av;
    acc_req = ar;
    working_accumulator = wa;
    alu_valid = lv;
    alu_req = lr;
    @(posedge clk);
    #1;
    scramble();
    @(posedge clk);
    #1;
  endtask

  // Read: lat counts edges after the taking edge, zero when no answer came
  task automatic rd(input ipa_acc_req_t ar, input logic [7:0] wa,
                    output logic [7:0] d, output int lat);
    lat = 0;
    d = 8'h00;
    acc_valid = 1'b1;
    acc_req = ar;
    working_accumulator = wa;
    @(posedge clk);
    #1;
    scramble();
    // Bounded wait for the answer strobe
    for (int n = 1; n <= 4 && lat == 0; n++) begin
      @(posedge clk);
      #1;
      if (acc_rvalid === 1'b1) begin
        lat = n;
        d = acc_rdata;
      end
    end
  endtask
endmodule // ipa_exec_model

// file: testbench/ipa_indirect_flags_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module ipa_indirect_flags_bench;
  import ipa_pkg::*;
  // One flag test case: operation, operands, result, flags byte
  typedef struct packed {
    ipa_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [7:0] f;
  } ipa_case_t;
  localparam ipa_case_t CASES [8] = '{
    '{ALU_ADD, 8'h7f, 8'h01, 8'h80, 8'h1a}, '{ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h07},
    '{ALU_SUB, 8'h05, 8'h03, 8'h02, 8'h03}, '{ALU_SUB, 8'h03, 8'h05, 8'hfe, 8'h10},
    '{ALU_SUB, 8'h80, 8'h01, 8'h7f, 8'h09}, '{ALU_LOGIC, 8'h5a, 8'h00, 8'h00, 8'h0d},
    '{ALU_ROT_LEFT, 8'h88, 8'h00, 8'h11, 8'h0b}, '{ALU_ROT_RIGHT, 8'h11, 8'h00, 8'h88, 8'h1b}};
  // Pointer-one mode walk: window address, data, pointer after
  localparam logic [7:0] MA [4] = '{8'hda, 8'hdb, 8'hd9, 8'hd8};
  localparam logic [7:0] MD [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  localparam logic [11:0] MP [4] = '{12'h100, 12'h101, 12'h100, 12'h100};

  logic clk; // Core clock
  logic resetn; // Reset, low
  logic acc_valid; // Access strobe
  ipa_acc_req_t acc_req; // Access request
  logic [7:0] working_accumulator; // Index
  logic alu_valid; // Flag update strobe
  ipa_alu_req_t alu_req; // Operation
  logic acc_rvalid; // Read answer strobe
  logic [7:0] acc_rdata; // Read data
  logic [7:0] alu_result; // Result
  logic [7:0] alu_condition_flags; // Flags byte
  logic [11:0] pointer_zero; // Pointer 0
  logic [11:0] pointer_one; // Pointer 1
  logic [11:0] pointer_two; // Pointer 2
  logic [3:0] bank_select_value; // Bank
  int miscompares; // Mismatch count
  int checks; // Comparison count
  logic [7:0] d; // Last read data
  int lat; // Last read latency

  ipa_indirect_flags uut (.clk(clk), .resetn(resetn), .acc_valid(acc_valid),
    .acc_req(acc_req), .working_accumulator(working_accumulator), .alu_valid(alu_valid),
    .alu_req(alu_req), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata),
    .alu_result(alu_result), .alu_condition_flags(alu_condition_flags),
    .pointer_zero(pointer_zero), .pointer_one(pointer_one), .pointer_two(pointer_two),
    .bank_select_value(bank_select_value));
  ipa_exec_model exm (.clk(clk), .acc_valid(acc_valid), .acc_req(acc_req),
    .working_accumulator(working_accumulator), .alu_valid(alu_valid), .alu_req(alu_req),
    .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata));

  // Request builders
  function automatic ipa_acc_req_t rq(input logic w, input logic ub, input logic [7:0] a,
                                      input logic [7:0] v);
    return '{w, ub, a, v};
  endfunction
  function automatic ipa_alu_req_t aq(input ipa_alu_op_t o, input logic [7:0] a,
                                      input logic [7:0] b);
    return '{o, a, b};
  endfunction

  // Plain write, no flag update alongside
  task automatic wr(input logic ub, input logic [7:0] a, input logic [7:0] v);
    exm.cyc(1'b1, rq(1'b1, ub, a, v), 8'h00, 1'b0, aq(ALU_ADD, 8'h00, 8'h00));
  endtask
  // Flag update alone, access strobe idle
  task automatic alu(input ipa_alu_op_t o, input logic [7:0] a, input logic [7:0] b);
    exm.cyc(1'b0, rq(1'b0, 1'b0, 8'h00, 8'h00), 8'h00, 1'b1, aq(o, a, b));
  endtask
  // Pointer load, high part first
  task automatic setp(input int n, input logic [11:0] v);
    wr(1'b0, 8'(8'hc3 + 2 * n), {4'h0, v[11:8]});
    wr(1'b0, 8'(8'hc2 + 2 * n), v[7:0]);
  endtask
  // Answer strobe stands one edge after the taking edge; a missing answer ends the run
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] wa,
                        input logic [7:0] ex);
    exm.rd(rq(1'b0, 1'b0, a, 8'h00), wa, d, lat);
    `CHK("read latency", 1, lat)
    if (lat == 0) begin
      report_and_stop();
    end
    `CHK(nm, ex, d)
  endtask

  // Single closing point of the run
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    @(posedge clk);
    #1;
    `CHK("pointers", 36'h0, {pointer_zero, pointer_one, pointer_two})
    `CHK("bank", 4'h0, bank_select_value)
    // Bank select keeps low nibble, bank-relative write lands in that page
    wr(1'b0, 8'hc1, 8'hf3);
    `CHK("bank", 4'h3, bank_select_value)
    rd_chk("bank read", 8'hc1, 8'h00, 8'h03);
    wr(1'b1, 8'h10, 8'h5a);
    setp(1, 12'h310);
    `CHK("pointer one", 12'h310, pointer_one)
    rd_chk("pointer high read", 8'hc5, 8'h00, 8'h03);
    rd_chk("plain read", 8'hd8, 8'h00, 8'h5a);
    // Mode walk across a low-byte carry
    setp(1, 12'h0ff);
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, MA[i], MD[i]);
      `CHK("pointer one step", MP[i], pointer_one)
    end
    rd_chk("indexed minus", 8'hdc, 8'hff, 8'h11);
    rd_chk("indexed plus", 8'hdc, 8'h01, 8'h33);
    rd_chk("plain after steps", 8'hd8, 8'h00, 8'h44);
    `CHK("pointer one kept", 12'h100, pointer_one)
    // Wrap both ways, flags must not notice a zero pointer
    alu(ALU_ADD, 8'h01, 8'h01);
    setp(2, 12'hfff);
    exm.rd(rq(1'b0, 1'b0, 8'he2, 8'h00), 8'h00, d, lat);
    `CHK("pointer two wrap up", 12'h000, pointer_two)
    `CHK("flags after step", 8'h00, alu_condition_flags)
    exm.rd(rq(1'b0, 1'b0, 8'he1, 8'h00), 8'h00, d, lat);
    `CHK("pointer two wrap down", 12'hfff, pointer_two)
    `CHK("pointer one apart", 12'h100, pointer_one)
    // Pointer aimed at a virtual operand
    setp(0, 12'hfd0);
    rd_chk("virtual read", 8'hd0, 8'h00, 8'h00);
    `CHK("flags zero set", 8'h04, alu_condition_flags)
    alu(ALU_ADD, 8'h7f, 8'h01);
    exm.cyc(1'b1, rq(1'b1, 1'b0, 8'hd0, 8'h77), 8'h00, 1'b1, aq(ALU_ADD, 8'hff, 8'h01));
    `CHK("flags after virtual write", 8'h1a, alu_condition_flags)
    `CHK("result still updates", 8'h00, alu_result)
    `CHK("pointer zero kept", 12'hfd0, pointer_zero)
    // Pointer aimed at its own low byte: the write beats the step
    setp(0, 12'hfc2);
    wr(1'b0, 8'hd2, 8'h55);
    `CHK("pointer zero own write", 12'hf55, pointer_zero)
    // Flags byte: direct write, then write losing to an operation
    wr(1'b0, 8'hc0, 8'hff);
    `CHK("flags direct", 8'h1f, alu_condition_flags)
    rd_chk("flags read", 8'hc0, 8'h00, 8'h1f);
    exm.cyc(1'b1, rq(1'b1, 1'b0, 8'hc0, 8'h00), 8'h00, 1'b1, aq(ALU_SUB, 8'h05, 8'h03));
    `CHK("flags over write", 8'h03, alu_condition_flags)
    // Arithmetic, logic and rotate flag table
    for (int i = 0; i < 8; i++) begin
      alu(CASES[i].op, CASES[i].a, CASES[i].b);
      `CHK("result", CASES[i].r, alu_result)
      `CHK("flags", CASES[i].f, alu_condition_flags)
    end
    report_and_stop();
  end
endmodule // ipa_indirect_flags_bench
